// ### haptic_driver_i2c_register_slave_tb_top.sv
// Bench joining host and device ends over one bus carrier.
// Assumes 16 registers at the device; higher addresses are missing.
`default_nettype none

module haptic_driver_i2c_register_slave_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  logic cmd_read_i = 1'b0;
  logic [7:0] cmd_reg_i = 8'h00;
  logic [7:0] cmd_data_i = 8'h00;
  logic enable_i = 1'b1;
  logic wr_mode_i = 1'b0;
  logic mode_v = 1'b0;
  logic cmd_ready_o, done_o, nack_o, wr_en_o, busy_o;
  logic [7:0] rd_data_o, wr_addr_o, wr_data_o, rd_addr_o;
  logic [7:0] mem_q [16];
  logic [7:0] shadow [16];
  logic [7:0] edge_r [4] = '{8'h00, 8'h0F, 8'h10, 8'hFF};
  logic [17:0] exp_q [$];
  logic [15:0] wexp_q [$];
  logic [17:0] e;
  logic [15:0] w;
  int err_count = 0;
  int samples_checked = 0;
  int seed = 32'h09d1;
  // Miss data is RD_MISS, 8'h00; addresses 8'h10 and up miss
  wire rd_hit_w = (rd_addr_o < 8'h10);
  wire [7:0] rd_data_w = mem_q[rd_addr_o[3:0]];

  initial begin
    forever #2 core_clk_i = ~core_clk_i;
  end

  hdi_bus_if hdi_bus_if_inst ();
  hdi_host_end #(.QTR_CYC(16), .FILT_LEN(2)) hdi_host_end_inst (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .bus(hdi_bus_if_inst.host),
    .cmd_valid_i(cmd_valid_i), .cmd_read_i(cmd_read_i),
    .cmd_reg_i(cmd_reg_i), .cmd_data_i(cmd_data_i),
    .cmd_ready_o(cmd_ready_o), .done_o(done_o), .nack_o(nack_o),
    .rd_data_o(rd_data_o));
  hdi_dev_end #(.FILT_LEN(2)) hdi_dev_end_inst (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .bus(hdi_bus_if_inst.dev),
    .enable_i(enable_i), .wr_mode_i(wr_mode_i), .wr_en_o(wr_en_o),
    .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .rd_addr_o(rd_addr_o),
    .rd_data_i(rd_data_w), .rd_hit_i(rd_hit_w), .busy_o(busy_o));
  hdi_bus_asserts hdi_bus_asserts_inst (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .enable_i(enable_i),
    .scl_oe_host(hdi_bus_if_inst.scl_oe_host),
    .sda_oe_host(hdi_bus_if_inst.sda_oe_host),
    .sda_oe_dev(hdi_bus_if_inst.sda_oe_dev),
    .scl(hdi_bus_if_inst.scl), .sda(hdi_bus_if_inst.sda));

  // ----------------------------------------
  // Compare and report
  // ----------------------------------------
  task automatic cmp_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_flag

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_byte

  task automatic print_verdict();
    $display("checked=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------
  // Driver
  // ----------------------------------------
  task automatic do_cmd(input logic rd, input logic [7:0] r,
                        input logic [7:0] d, input logic nak);
    int n;
    // Pointer: page write advances, repeat write and reads stay
    exp_q.push_back({(rd || mode_v) ? r : r + 8'h01, rd, nak,
                     (r < 8'h10) ? shadow[r[3:0]] : hdi_pkg::RD_MISS});
    if (!rd && !nak) begin
      wexp_q.push_back({r, d});
      if (r < 8'h10) begin
        shadow[r[3:0]] = d;
      end
    end
    cmd_valid_i <= 1'b1;
    cmd_read_i <= rd;
    cmd_reg_i <= r;
    cmd_data_i <= d;
    @(posedge core_clk_i);
    cmd_valid_i <= 1'b0;
    // Bounded wait; a read takes about 2500 cycles
    n = 0;
    while (done_o !== 1'b1) begin
      @(posedge core_clk_i);
      n++;
      if (n > 6000) begin
        err_count++;
        print_verdict();
      end
    end
  endtask : do_cmd

  // ----------------------------------------
  // Monitors
  // ----------------------------------------
  always @(posedge core_clk_i) begin
    if (wr_en_o === 1'b1) begin
      if (wr_addr_o < 8'h10) begin
        mem_q[wr_addr_o[3:0]] <= wr_data_o;
      end
      if (wexp_q.size() == 0) begin
        cmp_flag(wr_en_o, 1'b0);
      end else begin
        w = wexp_q.pop_front();
        cmp_byte(wr_addr_o, w[15:8]);
        cmp_byte(wr_data_o, w[7:0]);
      end
    end
    if (done_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        cmp_flag(done_o, 1'b0);
      end else begin
        e = exp_q.pop_front();
        cmp_flag(nack_o, e[8]);
        cmp_flag(busy_o, 1'b0);
        cmp_flag(cmd_ready_o, 1'b1);
        if (!e[8]) begin
          cmp_byte(rd_addr_o, e[17:10]);
        end
        if (e[9] && !e[8]) begin
          cmp_byte(rd_data_o, e[7:0]);
        end
      end
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] r;
    for (int i = 0; i < 16; i++) begin
      mem_q[i] = 8'hC3 ^ 8'(i);
      shadow[i] = 8'hC3 ^ 8'(i);
    end
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    // back-to-back write then read, both modes
    for (int i = 0; i < 16; i++) begin
      r = 8'($random(seed)) & 8'h1F;
      mode_v = 1'($random(seed));
      wr_mode_i <= mode_v;
      do_cmd(1'b0, r, 8'($random(seed)), 1'b0);
      do_cmd(1'b1, r, 8'h00, 1'b0);
    end
    do_cmd(1'b0, 8'hFF, 8'h5A, 1'b0);
    foreach (edge_r[k]) begin
      do_cmd(1'b1, edge_r[k], 8'h00, 1'b0);
    end
    enable_i <= 1'b0;
    do_cmd(1'b0, 8'h03, 8'h77, 1'b1);
    do_cmd(1'b1, 8'h03, 8'h00, 1'b1);
    enable_i <= 1'b1;
    do_cmd(1'b1, 8'h03, 8'h00, 1'b0);
    repeat (20) @(posedge core_clk_i);
    cmp_flag(exp_q.size() == 0 && wexp_q.size() == 0, 1'b1);
    print_verdict();
  end
endmodule : haptic_driver_i2c_register_slave_tb_top

`default_nettype wire

// ### hdi_bus_asserts.sv
// Concurrent checks on the two-wire bus between host and device ends.
// Assumes ideal open-drain lines as resolved by the bus carrier.
`default_nettype none

module hdi_bus_asserts (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic scl_oe_host,
  input wire logic sda_oe_host,
  input wire logic sda_oe_dev,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  // ----------------------------------------
  // Byte tracking
  // ----------------------------------------
  logic scl_q, sda_q, first_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  wire rise_w = scl & ~scl_q;
  wire start_w = scl & scl_q & sda_q & ~sda;
  wire slot_w = rise_w & (cnt_q == 4'h8) & first_q;
  wire match_w = enable_i & (sh_q[7:1] == hdi_pkg::DEV_ADDR);

  always_ff @(posedge core_clk_i) begin
    scl_q <= scl;
    sda_q <= sda;
    if (rst_i || start_w) begin
      cnt_q <= 4'h0;
      first_q <= 1'b1;
    end else if (rise_w) begin
      sh_q <= {sh_q[6:0], sda};
      cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
      first_q <= first_q & (cnt_q != 4'h8);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $past(scl) && $rose(sda);
  endsequence
  sequence s_addr_ok;
    slot_w && match_w;
  endsequence
  sequence s_addr_bad;
    slot_w && !match_w;
  endsequence

  chk_addr_ack_given: assert property (s_addr_ok |-> !sda)
    else $error("own address not acknowledged");
  chk_addr_ack_held: assert property (s_addr_bad |-> sda)
    else $error("acknowledge without a match");
  chk_dev_edge_low: assert property (
    $changed(sda_oe_dev) |-> !scl && !$past(scl))
    else $error("device data moved while clock high");
  chk_filter_delay: assert property (
    $rose(sda_oe_dev) |-> !$past(scl, 3))
    else $error("device reacted before filtering");
  // Both may pull at once on a wired line; only a sent bit must be clean
  chk_no_clash: assert property (
    rise_w && sda_oe_dev |-> !sda_oe_host)
    else $error("host pulls data line while device sends");
  chk_start_quiet: assert property (
    s_start |-> (scl && !sda_oe_dev) [*8])
    else $error("device active after start");
  chk_stop_idle: assert property (
    s_stop |-> (scl && sda && !sda_oe_dev) [*8])
    else $error("bus not idle after stop");
  chk_dev_release: assert property (
    $rose(sda_oe_dev) |-> ##[1:700] !sda_oe_dev)
    else $error("device holds data line too long");
endmodule : hdi_bus_asserts

`default_nettype wire

// ### hdi_bus_if.sv
// Two-wire bus carrier joining host and device ends.
// Each party only pulls a line low; released lines read high.
`default_nettype none

interface hdi_bus_if;
  logic scl_oe_host;
  logic sda_oe_host;
  logic sda_oe_dev;
  logic scl;
  logic sda;

  // Wired-AND of the pull-downs
  assign scl = ~scl_oe_host;
  assign sda = ~(sda_oe_host | sda_oe_dev);

  modport host (
    output scl_oe_host,
    output sda_oe_host,
    input scl,
    input sda
  );

  modport dev (
    output sda_oe_dev,
    input scl,
    input sda
  );
endinterface : hdi_bus_if

`default_nettype wire

// ### hdi_dev_end.sv
// Device end: two-wire target giving access to a byte register space.
// Assumes rd_data_i/rd_hit_i follow rd_addr_o combinationally.
`default_nettype none

module hdi_dev_end #(
  parameter int unsigned FILT_LEN = hdi_pkg::FILTER_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  hdi_bus_if.dev bus,
  input wire logic enable_i,
  input wire logic wr_mode_i,
  output logic wr_en_o,
  output logic [7:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  output logic [7:0] rd_addr_o,
  input wire logic [7:0] rd_data_i,
  input wire logic rd_hit_i,
  output logic busy_o
);

  // ----------------------------------------
  // Line conditioning
  // ----------------------------------------
  logic [1:0] lines_f;
  logic scl_q;
  logic sda_q;

  // sampled, no tie to bus rate
  hdi_glitch_filter #(
    .WIDTH(2),
    .LEN(FILT_LEN)
  ) u_filter (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .pin_i({bus.scl, bus.sda}),
    .level_o(lines_f)
  );

  wire logic scl_f = lines_f[1];
  wire logic sda_f = lines_f[0];
  wire logic scl_rise = scl_f & ~scl_q;
  wire logic scl_fall = ~scl_f & scl_q;
  wire logic start_det = scl_f & scl_q & sda_q & ~sda_f;
  wire logic stop_det = scl_f & scl_q & ~sda_q & sda_f;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      scl_q <= hdi_pkg::IDLE_LEVEL;
      sda_q <= hdi_pkg::IDLE_LEVEL;
    end else begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  // ----------------------------------------
  // Protocol state
  // ----------------------------------------
  hdi_pkg::hdi_dev_state_t state_q, state_d;
  logic [1:0] kind_q, kind_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] ptr_q, ptr_d;
  logic rd_q, rd_d;
  logic oe_q, oe_d;
  logic mack_q, mack_d;
  logic wr_en_q, wr_en_d;
  logic [7:0] wr_addr_q, wr_addr_d;
  logic [7:0] wr_data_q, wr_data_d;

  wire logic addr_hit = enable_i && (sh_q[7:1] == hdi_pkg::DEV_ADDR);
  wire logic byte_done = scl_fall && (cnt_q == hdi_pkg::BIT_LAST);
  wire logic [7:0] rd_byte = rd_hit_i ? rd_data_i : hdi_pkg::RD_MISS;
  wire logic [7:0] tx_load = {rd_byte[6:0], 1'b0};
  wire logic tx_first_oe = ~rd_byte[7];
  wire logic [7:0] ptr_inc = ptr_q + 1'b1;

  always_comb begin
    state_d = state_q;
    kind_d = kind_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    rd_d = rd_q;
    oe_d = oe_q;
    mack_d = mack_q;
    wr_en_d = 1'b0;
    wr_addr_d = wr_addr_q;
    wr_data_d = wr_data_q;
    if (start_det) begin
      state_d = hdi_pkg::DST_RX;
      kind_d = hdi_pkg::KIND_ADDR;
      cnt_d = '0;
      oe_d = 1'b0;
    end else if (stop_det) begin
      state_d = hdi_pkg::DST_IDLE;
      oe_d = 1'b0;
    end else begin
      case (state_q)
        hdi_pkg::DST_RX: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_f};
            cnt_d = cnt_q + 1'b1;
          end else if (byte_done) begin
            cnt_d = '0;
            state_d = hdi_pkg::DST_ACK;
            oe_d = 1'b1;
            case (kind_q)
              hdi_pkg::KIND_ADDR: begin
                rd_d = sh_q[0];
                kind_d = hdi_pkg::KIND_REG;
                if (!addr_hit) begin
                  state_d = hdi_pkg::DST_IDLE;
                  oe_d = 1'b0;
                end
              end
              hdi_pkg::KIND_REG: begin
                ptr_d = sh_q;
                kind_d = hdi_pkg::KIND_DATA;
              end
              default: begin
                wr_en_d = 1'b1;
                wr_addr_d = ptr_q;
                wr_data_d = sh_q;
                if (wr_mode_i) begin
                  kind_d = hdi_pkg::KIND_REG;
                end else begin
                  ptr_d = ptr_inc;
                end
              end
            endcase
          end
        end
        hdi_pkg::DST_ACK: begin
          if (scl_fall) begin
            if (rd_q) begin
              state_d = hdi_pkg::DST_TX;
              oe_d = tx_first_oe;
              sh_d = tx_load;
              cnt_d = 4'h1;
            end else begin
              state_d = hdi_pkg::DST_RX;
              oe_d = 1'b0;
            end
          end
        end
        hdi_pkg::DST_TX: begin
          if (byte_done) begin
            state_d = hdi_pkg::DST_MACK;
            oe_d = 1'b0;
          end else if (scl_fall) begin
            // a one is a released line
            oe_d = ~sh_q[7];
            sh_d = {sh_q[6:0], 1'b0};
            cnt_d = cnt_q + 1'b1;
          end
        end
        hdi_pkg::DST_MACK: begin
          if (scl_rise) begin
            mack_d = ~sda_f;
            if (!sda_f && !wr_mode_i) begin
              ptr_d = ptr_inc;
            end
          end else if (scl_fall) begin
            if (mack_q) begin
              state_d = hdi_pkg::DST_TX;
              oe_d = tx_first_oe;
              sh_d = tx_load;
              cnt_d = 4'h1;
            end else begin
              state_d = hdi_pkg::DST_IDLE;
            end
          end
        end
        default: begin
          state_d = hdi_pkg::DST_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= hdi_pkg::DST_IDLE;
      kind_q <= hdi_pkg::KIND_ADDR;
      cnt_q <= '0;
      sh_q <= '0;
      ptr_q <= '0;
      rd_q <= 1'b0;
      oe_q <= 1'b0;
      mack_q <= 1'b0;
    end else begin
      state_q <= state_d;
      kind_q <= kind_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      rd_q <= rd_d;
      oe_q <= oe_d;
      mack_q <= mack_d;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wr_en_q <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= '0;
    end else begin
      wr_en_q <= wr_en_d;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // no clock pin, never starts frames
  // filter far shorter than 1 MHz half period
  assign bus.sda_oe_dev = oe_q;
  assign wr_en_o = wr_en_q;
  assign wr_addr_o = wr_addr_q;
  assign wr_data_o = wr_data_q;
  assign rd_addr_o = ptr_q;
  assign busy_o = (state_q != hdi_pkg::DST_IDLE);
endmodule : hdi_dev_end

`default_nettype wire

// ### hdi_glitch_filter.sv
// Two-flop synchroniser plus stability filter per bus line.
// Assumes inputs are asynchronous to core_clk_i.
`default_nettype none

module hdi_glitch_filter #(
  parameter int unsigned WIDTH = 2,
  parameter int unsigned LEN = 4
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);

  localparam int unsigned CW = $clog2(LEN + 1);
  localparam logic [CW-1:0] CNT_END = CW'(LEN - 1);

  // ----------------------------------------
  // Per line synchroniser and filter
  // ----------------------------------------
  for (genvar g = 0; g < WIDTH; g++) begin : g_line
    logic meta_q;
    logic sync_q;
    logic lvl_q;
    logic [CW-1:0] cnt_q;
    wire logic differ = sync_q ^ lvl_q;
    wire logic settle = differ && (cnt_q == CNT_END);

    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        meta_q <= hdi_pkg::IDLE_LEVEL;
        sync_q <= hdi_pkg::IDLE_LEVEL;
      end else begin
        meta_q <= pin_i[g];
        sync_q <= meta_q;
      end
    end

    // Spikes shorter than LEN cycles never reach the level
    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        lvl_q <= hdi_pkg::IDLE_LEVEL;
        cnt_q <= '0;
      end else if (!differ || settle) begin
        lvl_q <= sync_q;
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end

    assign level_o[g] = lvl_q;
  end

endmodule : hdi_glitch_filter

`default_nettype wire

// ### hdi_host_end.sv
// Host end: bus controller issuing single register writes and reads.
// Assumes the device never stretches the clock.
`default_nettype none

module hdi_host_end #(
  parameter int unsigned QTR_CYC = hdi_pkg::SCL_QTR_CYC,
  parameter int unsigned FILT_LEN = hdi_pkg::FILTER_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  hdi_bus_if.host bus,
  input wire logic cmd_valid_i,
  input wire logic cmd_read_i,
  input wire logic [7:0] cmd_reg_i,
  input wire logic [7:0] cmd_data_i,
  output logic cmd_ready_o,
  output logic done_o,
  output logic nack_o,
  output logic [7:0] rd_data_o
);

  localparam int unsigned TW = $clog2(QTR_CYC + 1);
  localparam logic [TW-1:0] TICK_END = TW'(QTR_CYC - 1);

  // ----------------------------------------
  // Data line sampling and quarter-bit timer
  // ----------------------------------------
  logic sda_s;
  logic [TW-1:0] tcnt_q;

  hdi_glitch_filter #(
    .WIDTH(1),
    .LEN(FILT_LEN)
  ) u_filter (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .pin_i(bus.sda),
    .level_o(sda_s)
  );

  hdi_pkg::hdi_host_state_t state_q, state_d;
  logic [2:0] step_q, step_d;
  logic [3:0] bit_q, bit_d;
  logic [1:0] ph_q, ph_d;
  logic scl_oe_q, scl_oe_d;
  logic sda_oe_q, sda_oe_d;
  logic ack_q, ack_d;
  logic rd_q, rd_d;
  logic [7:0] reg_q, reg_d;
  logic [7:0] data_q, data_d;
  logic [7:0] rx_q, rx_d;
  logic done_q, done_d;
  logic nack_q, nack_d;

  wire logic idle = (state_q == hdi_pkg::HST_IDLE);
  wire logic tick = !idle && (tcnt_q == TICK_END);
  wire logic accept = idle && cmd_valid_i;
  wire logic ack_bit = (bit_q == hdi_pkg::BIT_LAST);
  wire logic [2:0] last_step =
    rd_q ? hdi_pkg::HSTEP_RDATA : hdi_pkg::HSTEP_DATA;
  wire logic rd_byte = (step_q == hdi_pkg::HSTEP_RDATA);
  wire logic to_sr = rd_q && (step_q == hdi_pkg::HSTEP_REG);
  wire logic [7:0] tx_byte =
    (step_q == hdi_pkg::HSTEP_ADDR_W) ?
      {hdi_pkg::DEV_ADDR, hdi_pkg::RW_WRITE} :
    (step_q == hdi_pkg::HSTEP_REG) ? reg_q :
    (step_q == hdi_pkg::HSTEP_DATA) ? data_q :
    (step_q == hdi_pkg::HSTEP_ADDR_R) ? {hdi_pkg::DEV_ADDR, hdi_pkg::RW_READ} :
    hdi_pkg::BYTE_RELEASE;
  // MSB first: index 7 - bit
  wire logic cur_bit = tx_byte[~bit_q[2:0]];

  always_ff @(posedge core_clk_i) begin
    if (rst_i || idle || tick) begin
      tcnt_q <= '0;
    end else begin
      tcnt_q <= tcnt_q + 1'b1;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    step_d = step_q;
    bit_d = bit_q;
    ph_d = ph_q;
    scl_oe_d = scl_oe_q;
    sda_oe_d = sda_oe_q;
    ack_d = ack_q;
    rd_d = rd_q;
    reg_d = reg_q;
    data_d = data_q;
    rx_d = rx_q;
    done_d = 1'b0;
    nack_d = nack_q;
    if (accept) begin
      state_d = hdi_pkg::HST_START;
      step_d = hdi_pkg::HSTEP_START;
      ph_d = hdi_pkg::PH_SETUP;
      rd_d = cmd_read_i;
      reg_d = cmd_reg_i;
      data_d = cmd_data_i;
      nack_d = 1'b0;
    end else if (tick) begin
      ph_d = ph_q + 1'b1;
      case (state_q)
        hdi_pkg::HST_START: begin
          case (ph_q)
            hdi_pkg::PH_SETUP: sda_oe_d = 1'b0;
            hdi_pkg::PH_RISE: scl_oe_d = 1'b0;
            hdi_pkg::PH_SAMPLE: sda_oe_d = 1'b1;
            default: begin
              scl_oe_d = 1'b1;
              step_d = step_q + 1'b1;
              bit_d = '0;
              state_d = hdi_pkg::HST_BYTE;
            end
          endcase
        end
        hdi_pkg::HST_BYTE: begin
          case (ph_q)
            hdi_pkg::PH_SETUP: sda_oe_d = !ack_bit && !cur_bit;
            hdi_pkg::PH_RISE: scl_oe_d = 1'b0;
            hdi_pkg::PH_SAMPLE: begin
              if (ack_bit) begin
                ack_d = ~sda_s;
              end else begin
                rx_d = {rx_q[6:0], sda_s};
              end
            end
            default: begin
              scl_oe_d = 1'b1;
              bit_d = bit_q + 1'b1;
              if (ack_bit) begin
                bit_d = '0;
                step_d = step_q + 1'b1;
                // NAK on read data, then STOP
                if ((!rd_byte && !ack_q) || (step_q == last_step)) begin
                  state_d = hdi_pkg::HST_STOP;
                  nack_d = !rd_byte && !ack_q;
                end else if (to_sr) begin
                  state_d = hdi_pkg::HST_START;
                end
              end
            end
          endcase
        end
        hdi_pkg::HST_STOP: begin
          case (ph_q)
            hdi_pkg::PH_SETUP: sda_oe_d = 1'b1;
            hdi_pkg::PH_RISE: scl_oe_d = 1'b0;
            hdi_pkg::PH_SAMPLE: sda_oe_d = 1'b0;
            default: begin
              state_d = hdi_pkg::HST_IDLE;
              done_d = 1'b1;
            end
          endcase
        end
        default: state_d = hdi_pkg::HST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= hdi_pkg::HST_IDLE;
      step_q <= hdi_pkg::HSTEP_START;
      bit_q <= '0;
      ph_q <= hdi_pkg::PH_SETUP;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      ack_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      state_q <= state_d;
      step_q <= step_d;
      bit_q <= bit_d;
      ph_q <= ph_d;
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
      ack_q <= ack_d;
      rd_q <= rd_d;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      reg_q <= '0;
      data_q <= '0;
      rx_q <= '0;
      done_q <= 1'b0;
      nack_q <= 1'b0;
    end else begin
      reg_q <= reg_d;
      data_q <= data_d;
      rx_q <= rx_d;
      done_q <= done_d;
      nack_q <= nack_d;
    end
  end

  assign bus.scl_oe_host = scl_oe_q;
  assign bus.sda_oe_host = sda_oe_q;
  assign cmd_ready_o = idle;
  assign done_o = done_q;
  assign nack_o = nack_q;
  assign rd_data_o = rx_q;

endmodule : hdi_host_end

`default_nettype wire

// ### hdi_pkg.sv
// Shared constants and types for the two-wire register link.
// Assumes one core clock per end; bus lines are open drain with pull-ups.
`default_nettype none

package hdi_pkg;

  // ----------------------------------------
  // Addressing
  // ----------------------------------------
  localparam logic [6:0] DEV_ADDR = 7'h4A;
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;
  localparam logic [7:0] RD_MISS = 8'h00;
  localparam logic [7:0] BYTE_RELEASE = 8'hFF;
  localparam logic IDLE_LEVEL = 1'b1;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CORE_CLK_HZ = 250_000_000;
  localparam int unsigned SCL_MAX_HZ = 1_000_000;
  localparam int unsigned FILTER_NS = 50;
  // Longest spike to reject, rounded down
  localparam int unsigned FILTER_CYC =
    (FILTER_NS * (CORE_CLK_HZ / 1_000_000)) / 1000;
  // Quarter bit time of the host clock, rounded up to stay at or below max
  localparam int unsigned SCL_QTR_CYC =
    (CORE_CLK_HZ + 4 * SCL_MAX_HZ - 1) / (4 * SCL_MAX_HZ);

  // ----------------------------------------
  // Byte framing
  // ----------------------------------------
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [1:0] PH_SETUP = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_SAMPLE = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;

  localparam logic [1:0] KIND_ADDR = 2'h0;
  localparam logic [1:0] KIND_REG = 2'h1;
  localparam logic [1:0] KIND_DATA = 2'h2;

  localparam logic [2:0] HSTEP_START = 3'h0;
  localparam logic [2:0] HSTEP_ADDR_W = 3'h1;
  localparam logic [2:0] HSTEP_REG = 3'h2;
  localparam logic [2:0] HSTEP_DATA = 3'h3;
  localparam logic [2:0] HSTEP_ADDR_R = 3'h4;
  localparam logic [2:0] HSTEP_RDATA = 3'h5;

  typedef enum logic [4:0] {
    DST_IDLE = 5'b00001,
    DST_RX = 5'b00010,
    DST_ACK = 5'b00100,
    DST_TX = 5'b01000,
    DST_MACK = 5'b10000
  } hdi_dev_state_t;

  typedef enum logic [3:0] {
    HST_IDLE = 4'b0001,
    HST_START = 4'b0010,
    HST_BYTE = 4'b0100,
    HST_STOP = 4'b1000
  } hdi_host_state_t;

endpackage : hdi_pkg

`default_nettype wire
